// [common/ipc_pkg.sv]
// Shared constants for the interrupt priority controller and its CPU end
package ipc_pkg;
  // Widths of the link between the two ends
  localparam int NUM_SRC   = 10;  // User sources handled here
  localparam int NUM_TRAP  = 8;   // Non-maskable trap sources
  localparam int ADDR_W    = 4;   // Device register index width
  localparam int DATA_W    = 16;  // Register width
  localparam int LVL_W     = 4;   // CPU level width (0..15)
  localparam int VEC_W     = 7;   // Vector number width
  localparam int STACK_DEPTH = 16; // Saved levels, one per nesting step

  // Device register indexes on the link bus
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0; // first_interrupt_control
  localparam logic [ADDR_W-1:0] REG_FLAG   = 4'h1; // flag_status_regs
  localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h2; // enable_control_regs
  localparam logic [ADDR_W-1:0] REG_PRIO0  = 4'h3; // priority_fault_a_dma5_audio
  localparam logic [ADDR_W-1:0] REG_PRIO1  = 4'h4; // priority_uart_errors_fault_b
  localparam logic [ADDR_W-1:0] REG_PRIO2  = 4'h5; // priority_can_tx_dma6_dma7
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6; // pending_level_vector_status

  // Field positions
  localparam int NEST_BIT       = 15; // nesting_disable in control register
  localparam int STATUS_LVL_POS = 8;  // new_cpu_level field
  localparam int STATUS_VEC_POS = 0;  // pending_vector_number field

  // Priority registers: reset values put every source at level 4
  localparam logic [DATA_W-1:0] PRIO_RST  [3] = '{16'h4044, 16'h0444, 16'h4444};
  localparam logic [DATA_W-1:0] PRIO_MASK [3] = '{16'h7077, 16'h0777, 16'h7777};

  // Sources in natural order: index 0 has the lowest vector address
  // audio, dma5, fault_a, fault_b, uart1_err, uart2_err, dma6, dma7, can1_tx, can2_tx
  localparam int SRC_REG [NUM_SRC] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
  localparam int SRC_POS [NUM_SRC] = '{0, 4, 12, 0, 4, 8, 0, 4, 8, 12};
  localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] =
    '{7'h44, 7'h45, 7'h47, 7'h48, 7'h49, 7'h4a, 7'h4c, 7'h4d, 7'h4e, 7'h4f};

  // Level thresholds
  localparam logic [LVL_W-1:0] LVL_TRAP_TOP = 4'hf; // Trap 0 level; trap t is 15-t
  localparam logic [LVL_W-1:0] LVL_TIMED_DISABLE_INSTR     = 4'h6; // Timed disable covers 1..6

  // Timed disable interval
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIMED_DISABLE_INSTR_TIME_NS  = 800;
  localparam int TIMED_DISABLE_INSTR_CYCLES   = TIMED_DISABLE_INSTR_TIME_NS / CLK_PERIOD_NS;

  // CPU end command registers (software port)
  localparam logic [4:0] HREG_SRL      = 5'h10; // status_low_byte
  localparam logic [4:0] HREG_CMD      = 5'h11; // Instruction triggers
  localparam logic [4:0] HREG_IRQ_STAT = 5'h12; // Sticky events, read only
  localparam logic [4:0] HREG_IRQ_CLR  = 5'h13; // Write one to clear
  localparam logic [4:0] HREG_IRQ_EN   = 5'h14; // Event enables
  localparam logic [4:0] HREG_LAST_VEC = 5'h15; // Last taken vector and level
  localparam int HOST_SEL_BIT = 4;              // Clear: forward to device
  localparam int SRL_LVL_POS  = 5;              // CPU level in status_low_byte
  localparam int CMD_RETURN_BIT = 0;            // return_from_interrupt_instr
  localparam int CMD_TIMED_DISABLE_INSTR_BIT   = 1;            // timed_disable_instr
  localparam int EV_TAKEN  = 0;                 // Interrupt taken event
  localparam int EV_RETURN = 1;                 // Return executed event
  localparam int NUM_EV    = 2;
endpackage : ipc_pkg

// [common/ipc_link_if.sv]
// Link between the interrupt controller and the CPU end
`timescale 1ns/10ps
interface ipc_link_if;
  import ipc_pkg::*;
  logic [ADDR_W-1:0] busAddr;      // Register index
  logic [DATA_W-1:0] busWdata;     // Write data
  logic              busWr;        // Write strobe
  logic              busRd;        // Read strobe
  logic [DATA_W-1:0] busRdata;     // Read data, cycle after busRd
  logic              intReq;       // Request to the CPU
  logic [LVL_W-1:0]  intLevel;     // Level of the request
  logic [VEC_W-1:0]  intVector;    // Vector of the request
  logic              intAck;       // CPU takes the request
  logic              intReturn;    // CPU returns from a routine
  logic [LVL_W-1:0]  cpuLevel;     // Current CPU level
  logic [LVL_W-1:0]  restoreLevel; // Level to restore on return
  logic              disiStart;    // Timed disable issued

  modport device (input busAddr, busWdata, busWr, busRd, intAck, intReturn, cpuLevel,
                  disiStart, output busRdata, intReq, intLevel, intVector, restoreLevel);
  modport host (output busAddr, busWdata, busWr, busRd, intAck, intReturn, cpuLevel,
                disiStart, input busRdata, intReq, intLevel, intVector, restoreLevel);
endinterface : ipc_link_if

// [logic/ipc_controller.sv]
// Interrupt controller end: flags, enables, priorities, arbitration
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module ipc_controller
  import ipc_pkg::*;
#(
  parameter int TIMED_DISABLE_INSTR_COUNT = TIMED_DISABLE_INSTR_CYCLES // Timed disable length in cycles
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  ipc_link_if.device               link,
  input  wire logic [NUM_SRC-1:0]  srcEvent,  // Peripheral request pulses
  input  wire logic [NUM_TRAP-1:0] trapEvent  // Trap condition pulses
);
  localparam int CNT_W = $clog2(TIMED_DISABLE_INSTR_COUNT + 1);
  localparam int SP_W  = $clog2(STACK_DEPTH + 1);

  // Refuse an interval that the counter cannot serve
  if (TIMED_DISABLE_INSTR_COUNT < 1) begin : g_bad_count
    $error("TIMED_DISABLE_INSTR_COUNT must be at least one cycle");
  end

  logic                nestDisable;              // Nesting disable bit
  logic [NUM_TRAP-1:0] trapFlag;                 // Sticky trap flags
  logic [NUM_SRC-1:0]  flag;                     // Sticky source flags
  logic [NUM_SRC-1:0]  enable;                   // Source enables
  logic [DATA_W-1:0]   prioReg [3];              // Three priority registers
  logic [2:0]          srcPrio [NUM_SRC];        // Per-source level field
  logic [LVL_W-1:0]    lvlStack [STACK_DEPTH];   // Saved CPU levels
  logic [SP_W-1:0]     sp;                       // Stack depth, nonzero in service
  logic [SP_W-1:0]     spTop;                    // Index of the newest saved level
  logic [CNT_W-1:0]    disiCount;                // Timed disable remaining
  logic                found;                    // A candidate exists
  logic [LVL_W-1:0]    bestLvl;                  // Winning level
  logic [VEC_W-1:0]    bestVec;                  // Winning vector
  logic [LVL_W-1:0]    userFloor;                // Users must exceed this
  logic                userBlock;                // Nesting forbids user entry
  logic [DATA_W-1:0]   statusWord;               // Status register view

  // Write decode used by every register process
  function automatic logic wrHit(input logic [ADDR_W-1:0] idx);
    return link.busWr && (link.busAddr == idx);
  endfunction : wrHit

  // Control register: nesting bit plus trap flags; a trap event beats a clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nestDisable <= 1'b0;
      trapFlag    <= '0;
    end else if (wrHit(REG_CTRL)) begin
      nestDisable <= link.busWdata[NEST_BIT];
      trapFlag    <= link.busWdata[NUM_TRAP-1:0] | trapEvent;
    end else begin
      trapFlag    <= trapFlag | trapEvent;
    end
  end

  // Source flags are only cleared by software; an event in the same cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag <= '0;
    end else if (wrHit(REG_FLAG)) begin
      flag <= link.busWdata[NUM_SRC-1:0] | srcEvent;
    end else begin
      flag <= flag | srcEvent;
    end
  end

  // Enables steer arbitration only; flags latch even while disabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable <= '0;
    end else if (wrHit(REG_ENABLE)) begin
      enable <= link.busWdata[NUM_SRC-1:0];
    end
  end

  // Priority registers, unimplemented bits held at zero
  for (genvar r = 0; r < 3; r++) begin : g_prio
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        prioReg[r] <= PRIO_RST[r];
      end else if (wrHit(REG_PRIO0 + ADDR_W'(r))) begin
        prioReg[r] <= link.busWdata & PRIO_MASK[r];
      end
    end
  end

  // Per-source level fields pulled out of the packed registers
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_field
    assign srcPrio[i] = prioReg[SRC_REG[i]][SRC_POS[i] +: 3];
  end

  // Timed disable counter, reloaded by each new instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disiCount <= '0;
    end else if (link.disiStart) begin
      disiCount <= CNT_W'(TIMED_DISABLE_INSTR_COUNT);
    end else if (disiCount != '0) begin
      disiCount <= disiCount - CNT_W'(1);
    end
  end

  // Stack depth: push on entry, pop on return; underflow is ignored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sp <= '0;
    end else if (link.intAck && sp != SP_W'(STACK_DEPTH)) begin
      sp <= sp + SP_W'(1);
    end else if (link.intReturn && sp != '0) begin
      sp <= sp - SP_W'(1);
    end
  end

  // Stack contents need no reset: an empty stack is never read
  always_ff @(posedge clock) begin
    if (link.intAck && sp != SP_W'(STACK_DEPTH)) begin
      lvlStack[sp[SP_W-2:0]] <= link.cpuLevel;
    end
  end

  // Level handed back to the CPU on return
  assign spTop = sp - SP_W'(1);
  assign link.restoreLevel = (sp == '0) ? link.cpuLevel : lvlStack[spTop[SP_W-2:0]];

  // Arbitration: traps first by level, users above the floor.
  // Strict compare keeps the lower index, hence the lower vector, on ties.
  always_comb begin
    found     = 1'b0;
    bestLvl   = '0;
    bestVec   = '0;
    userBlock = nestDisable && (sp != '0);
    userFloor = link.cpuLevel;
    if (disiCount != '0 && userFloor < LVL_TIMED_DISABLE_INSTR) begin
      userFloor = LVL_TIMED_DISABLE_INSTR;
    end
    // Traps ignore the floor, nesting and timed disable
    for (int t = 0; t < NUM_TRAP; t++) begin
      if (trapFlag[t] && (LVL_TRAP_TOP - LVL_W'(t)) > link.cpuLevel &&
          (LVL_TRAP_TOP - LVL_W'(t)) > bestLvl) begin
        found   = 1'b1;
        bestLvl = LVL_TRAP_TOP - LVL_W'(t);
        bestVec = VEC_W'(t);
      end
    end
    // Users: flagged, enabled, nonzero field, above floor
    for (int i = 0; i < NUM_SRC; i++) begin
      if (flag[i] && enable[i] && srcPrio[i] != 3'h0 && !userBlock &&
          {1'b0, srcPrio[i]} > userFloor && {1'b0, srcPrio[i]} > bestLvl) begin
        found   = 1'b1;
        bestLvl = {1'b0, srcPrio[i]};
        bestVec = SRC_VEC[i];
      end
    end
  end

  // Request registers toward the CPU; reloaded every cycle from the arbitration result
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.intReq    <= 1'b0;
      link.intLevel  <= '0;
      link.intVector <= '0;
    end else begin
      link.intReq    <= found;
      link.intLevel  <= bestLvl;
      link.intVector <= bestVec;
    end
  end

  // Status view built from the registered request
  always_comb begin
    statusWord = '0;
    statusWord[STATUS_LVL_POS +: LVL_W] = link.intReq ? link.intLevel : '0;
    statusWord[STATUS_VEC_POS +: VEC_W] = link.intReq ? link.intVector : '0;
  end

  // Read port: data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.busRdata <= '0;
    end else if (link.busRd) begin
      unique case (link.busAddr)
        REG_CTRL:   link.busRdata <= {nestDisable, 7'h00, trapFlag};
        REG_FLAG:   link.busRdata <= DATA_W'(flag);
        REG_ENABLE: link.busRdata <= DATA_W'(enable);
        REG_PRIO0:  link.busRdata <= prioReg[0];
        REG_PRIO1:  link.busRdata <= prioReg[1];
        REG_PRIO2:  link.busRdata <= prioReg[2];
        REG_STATUS: link.busRdata <= statusWord;
        default:    link.busRdata <= '0;
      endcase
    end
  end
endmodule : ipc_controller

// [logic/ipc_cpu_end.sv]
// CPU end: holds the CPU level, takes requests, forwards software accesses
`timescale 1ns/10ps
module ipc_cpu_end
  import ipc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  ipc_link_if.host               link,
  input  wire logic [4:0]        cmdAddr,   // Software address
  input  wire logic [DATA_W-1:0] cmdWdata,  // Software write data
  input  wire logic              cmdWr,     // Write strobe
  input  wire logic              cmdRd,     // Read strobe
  output logic      [DATA_W-1:0] cmdRdata,  // Read data, cycle after cmdRd
  output logic                   irq        // Enabled event pending
);
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,  // May take a request
    ST_SETTLE = 2'b10  // One cycle for the controller to see the new level
  } ipc_state_t;

  ipc_state_t        state;        // Entry sequencer
  logic [LVL_W-1:0]  cpuLevel;     // Current CPU priority level
  logic [NUM_EV-1:0] evStat;       // Sticky events
  logic [NUM_EV-1:0] evEn;         // Event enables
  logic [NUM_EV-1:0] evSet;        // Events this cycle
  logic [DATA_W-1:0] lastTaken;    // Vector and level of last entry
  logic [DATA_W-1:0] ownRdata;     // Local read data
  logic              rdFromDev;    // Last read went to the controller
  logic              takeReq;      // Accept the request now
  logic              localWr;      // Write to a local register
  logic              doReturn;     // Return instruction issued

  // Addresses below the local block pass straight to the controller
  assign link.busAddr  = cmdAddr[ADDR_W-1:0];
  assign link.busWdata = cmdWdata;
  assign link.busWr    = cmdWr && !cmdAddr[HOST_SEL_BIT];
  assign link.busRd    = cmdRd && !cmdAddr[HOST_SEL_BIT];
  assign localWr       = cmdWr && cmdAddr[HOST_SEL_BIT];
  assign link.cpuLevel = cpuLevel;

  // The controller already filters by level; the compare guards its stale cycle
  assign takeReq = (state == ST_RUN) && link.intReq && (link.intLevel > cpuLevel);
  assign link.intAck    = takeReq;
  assign doReturn       = localWr && cmdAddr == HREG_CMD && cmdWdata[CMD_RETURN_BIT];
  assign link.intReturn = doReturn && !takeReq;
  assign link.disiStart = localWr && cmdAddr == HREG_CMD && cmdWdata[CMD_TIMED_DISABLE_INSTR_BIT];
  assign evSet = {link.intReturn, takeReq};

  // Entry sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN:    if (takeReq) state <= ST_SETTLE;
        ST_SETTLE: state <= ST_RUN;
      endcase
    end
  end

  // CPU level: entry raises, return restores, software may set it directly
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpuLevel  <= '0;
      lastTaken <= '0;
    end else if (takeReq) begin
      cpuLevel  <= link.intLevel;
      lastTaken <= {4'h0, link.intLevel, 1'b0, link.intVector};
    end else if (link.intReturn) begin
      cpuLevel  <= link.restoreLevel;
    end else if (localWr && cmdAddr == HREG_SRL) begin
      cpuLevel  <= {1'b0, cmdWdata[SRL_LVL_POS +: 3]};
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evStat <= '0;
    end else if (localWr && cmdAddr == HREG_IRQ_CLR) begin
      evStat <= (evStat & ~cmdWdata[NUM_EV-1:0]) | evSet;
    end else begin
      evStat <= evStat | evSet;
    end
  end

  // Event enables
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evEn <= '0;
    end else if (localWr && cmdAddr == HREG_IRQ_EN) begin
      evEn <= cmdWdata[NUM_EV-1:0];
    end
  end

  assign irq = |(evStat & evEn);

  // Local reads, one cycle later; write-only and unmapped read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ownRdata  <= '0;
      rdFromDev <= 1'b0;
    end else begin
      rdFromDev <= link.busRd;
      if (cmdRd) begin
        unique case (cmdAddr)
          HREG_SRL:      ownRdata <= DATA_W'({cpuLevel[2:0], 5'h00});
          HREG_IRQ_STAT: ownRdata <= DATA_W'(evStat);
          HREG_IRQ_EN:   ownRdata <= DATA_W'(evEn);
          HREG_LAST_VEC: ownRdata <= lastTaken;
          default:       ownRdata <= '0;
        endcase
      end
    end
  end

  assign cmdRdata = rdFromDev ? link.busRdata : ownRdata;
endmodule : ipc_cpu_end

// [tb/ipc_checker.sv]
// Link checks between the controller end and the CPU end
`timescale 1ns/10ps
module ipc_checker
  import ipc_pkg::*;
#(
  parameter int TIMED_DISABLE_INSTR_COUNT = TIMED_DISABLE_INSTR_CYCLES // Timed disable length in cycles
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic [DATA_W-1:0] busWdata,
  input  wire logic              busWr,
  input  wire logic              busRd,
  input  wire logic [DATA_W-1:0] busRdata,
  input  wire logic              intReq,
  input  wire logic [LVL_W-1:0]  intLevel,
  input  wire logic [VEC_W-1:0]  intVector,
  input  wire logic              intAck,
  input  wire logic              intReturn,
  input  wire logic [LVL_W-1:0]  cpuLevel,
  input  wire logic [LVL_W-1:0]  restoreLevel,
  input  wire logic              disiStart
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic [DATA_W-1:0]  prio [3];  // Shadow of the priority registers
  logic [DATA_W-1:0]  prioQ [3]; // Shadow one cycle late, as requests lag state
  logic [NUM_SRC-1:0] en;        // Shadow of the enables
  logic [NUM_SRC-1:0] enQ;       // Enables one cycle late
  logic               nestOn;    // Nesting disable as last written
  int                 disiCnt;   // Timed disable interval left
  logic [LVL_W-1:0]   expLvl;    // Level the requesting source should carry
  logic               expEn;     // Requesting source is enabled

  // Track software writes seen on the link
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prio   <= PRIO_RST;
      en     <= '0;
      nestOn <= 1'b0;
    end else if (busWr) begin
      for (int r = 0; r < 3; r++) begin
        if (busAddr == REG_PRIO0 + 4'(r)) begin
          prio[r] <= busWdata & PRIO_MASK[r];
        end
      end
      if (busAddr == REG_ENABLE) begin
        en <= busWdata[NUM_SRC-1:0];
      end
      if (busAddr == REG_CTRL) begin
        nestOn <= busWdata[NEST_BIT];
      end
    end
  end

  // Delay the shadows to line up with the registered request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prioQ <= PRIO_RST;
      enQ   <= '0;
    end else begin
      prioQ <= prio;
      enQ   <= en;
    end
  end

  // Mirror the timed disable interval
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disiCnt <= 0;
    end else if (disiStart) begin
      disiCnt <= TIMED_DISABLE_INSTR_COUNT;
    end else if (disiCnt > 0) begin
      disiCnt <= disiCnt - 1;
    end
  end

  // Look up the field of whichever user source is requesting
  always_comb begin
    expLvl = '0;
    expEn  = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (intVector == SRC_VEC[i]) begin
        expLvl = {1'b0, prioQ[SRC_REG[i]][SRC_POS[i] +: 3]};
        expEn  = enQ[i];
      end
    end
  end

  a_req_beats_level: assert property (intReq |-> intLevel > $past(cpuLevel))
    else $error("request does not beat the CPU level");
  a_user_mask_seven: assert property (intReq && $past(cpuLevel) >= 4'h7 |-> intLevel >= 4'h8)
    else $error("user request passed a level seven CPU");
  a_user_field_level: assert property (intReq && intLevel < 4'h8 |->
    expEn && expLvl != 4'h0 && intLevel == expLvl)
    else $error("user request not enabled or at the wrong level");
  a_trap_fixed_level: assert property (intReq && intLevel >= 4'h8 |->
    intVector < 7'h08 && intLevel == LVL_TRAP_TOP - intVector[LVL_W-1:0])
    else $error("trap request carries a wrong level");
  a_ack_takes_level: assert property (intAck && intReq && intLevel > cpuLevel && !$past(intAck)
    |=> cpuLevel == $past(intLevel))
    else $error("accepted request did not set the CPU level");
  a_return_restores: assert property (intReturn && !intAck |=> cpuLevel == $past(restoreLevel))
    else $error("return did not restore the saved level");
  a_status_word: assert property (busRd && busAddr == REG_STATUS |=>
    busRdata == ({4'h0, $past(intLevel), 1'b0, $past(intVector)} & {DATA_W{$past(intReq)}}))
    else $error("status word differs from the pending request");
  a_timed_disable_instr_floor: assert property (intReq && disiCnt > 1 && disiCnt < TIMED_DISABLE_INSTR_COUNT |->
    intLevel >= 4'h7)
    else $error("timed disable let a low level through");
  a_nest_holds: assert property (intAck && nestOn ##1 !intReturn [*2] |=>
    !intReq || intLevel >= 4'h8)
    else $error("user request preempted with nesting disabled");
endmodule : ipc_checker

// [tb/tb_interrupt_priority_control.sv]
// Self-checking bench for the controller and CPU end pair
`timescale 1ns/10ps
module tb_interrupt_priority_control
  import ipc_pkg::*;
;
  localparam int TIMED_DISABLE_INSTR_SIM = 40; // Short timed disable keeps the run brief

  logic                clock;
  logic                rst_n;
  logic [4:0]          cmdAddr;
  logic [DATA_W-1:0]   cmdWdata;
  logic [DATA_W-1:0]   cmdRdata;
  logic                cmdWr;
  logic                cmdRd;
  logic                irq;
  logic [NUM_SRC-1:0]  srcEvent;
  logic [NUM_TRAP-1:0] trapEvent;
  logic [DATA_W-1:0]   rv;        // Random draw
  integer              seed;
  int                  bad_count;
  int                  compares;

  ipc_link_if link ();
  ipc_controller #(.TIMED_DISABLE_INSTR_COUNT(TIMED_DISABLE_INSTR_SIM)) ipc_controller_i (.clock(clock), .rst_n(rst_n),
    .link(link), .srcEvent(srcEvent), .trapEvent(trapEvent));
  ipc_cpu_end ipc_cpu_end_i (.clock(clock), .rst_n(rst_n), .link(link), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .irq(irq));
  ipc_checker #(.TIMED_DISABLE_INSTR_COUNT(TIMED_DISABLE_INSTR_SIM)) ipc_checker_i (.clock(clock), .rst_n(rst_n),
    .busAddr(link.busAddr), .busWdata(link.busWdata), .busWr(link.busWr),
    .busRd(link.busRd), .busRdata(link.busRdata), .intReq(link.intReq),
    .intLevel(link.intLevel), .intVector(link.intVector), .intAck(link.intAck),
    .intReturn(link.intReturn), .cpuLevel(link.cpuLevel),
    .restoreLevel(link.restoreLevel), .disiStart(link.disiStart));

  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Print counts and the verdict, then stop
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One-cycle software write
  task automatic wr(input logic [4:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    cmdWr    <= 1'b1;
    cmdAddr  <= a;
    cmdWdata <= d;
    @(posedge clock);
    cmdWr <= 1'b0;
  endtask : wr

  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [4:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock);
    cmdRd   <= 1'b1;
    cmdAddr <= a;
    @(posedge clock);
    cmdRd <= 1'b0;
    #1;
    check(cmdRdata, exp);
  endtask : rd

  task automatic pulse(input logic [NUM_SRC-1:0] s, input logic [NUM_TRAP-1:0] t);
    @(posedge clock);
    srcEvent  <= s;
    trapEvent <= t;
    @(posedge clock);
    srcEvent  <= '0;
    trapEvent <= '0;
  endtask : pulse

  // Last-entry word as the CPU end reports it: level over vector
  function automatic logic [DATA_W-1:0] taken_word(input logic [LVL_W-1:0] lvl,
                                                   input logic [VEC_W-1:0] vec);
    return {4'h0, lvl, 1'b0, vec};
  endfunction : taken_word

  // Wait boundedly for the taken interrupt, check what was taken, clear events
  task automatic take(input logic [LVL_W-1:0] lvl, input logic [VEC_W-1:0] vec);
    int n;
    for (n = 0; n < 200 && irq !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    check({15'h0000, irq}, 16'h0001);
    if (n == 200) begin
      report_and_stop();
    end else begin
      rd(HREG_LAST_VEC, taken_word(lvl, vec));
      wr(HREG_IRQ_CLR, 16'h0003);
    end
  endtask : take

  // Main sequence
  initial begin
    seed      = 32'hef2aa9ae;
    rst_n     = 1'b0;
    cmdAddr   = '0;
    cmdWdata  = '0;
    cmdWr     = 1'b0;
    cmdRd     = 1'b0;
    srcEvent  = '0;
    trapEvent = '0;
    bad_count = 0;
    compares  = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      rd({1'b0, REG_PRIO0 + 4'(r)}, PRIO_RST[r]);
    end
    rd(5'h1f, 16'h0000);
    // Random field writes; unimplemented bits must read back zero
    for (int k = 0; k < 12; k++) begin
      rv = 16'($random(seed));
      wr({1'b0, REG_PRIO0 + 4'(k % 3)}, rv);
      rd({1'b0, REG_PRIO0 + 4'(k % 3)}, rv & PRIO_MASK[k % 3]);
    end
    // Random events with nothing enabled: flags hold, no request
    rv = 16'($random(seed));
    pulse(rv[NUM_SRC-1:0], 8'h00);
    rd({1'b0, REG_FLAG}, {6'h00, rv[NUM_SRC-1:0]});
    rd({1'b0, REG_STATUS}, 16'h0000);
    // CPU at seven: user sources withheld, a trap still gets through
    wr(HREG_SRL, 16'h00e0);
    wr({1'b0, REG_PRIO0}, 16'h5005);
    wr({1'b0, REG_FLAG}, 16'h0000);
    wr({1'b0, REG_ENABLE}, 16'h0007);
    wr(HREG_IRQ_EN, 16'h0001);
    pulse(10'h007, 8'h00);
    rd({1'b0, REG_STATUS}, 16'h0000);
    pulse(10'h000, 8'h04);
    take(LVL_TRAP_TOP - 4'h2, 7'h02);
    rd({1'b0, REG_CTRL}, 16'h0004);
    wr({1'b0, REG_CTRL}, 16'h0000);
    wr(HREG_CMD, 16'h0001);
    rd(HREG_SRL, 16'h00e0);
    rd(HREG_IRQ_STAT, 16'h0002);
    check({15'h0000, irq}, 16'h0000);
    // Equal levels, lowest vector first; uncleared flag is taken again
    wr(HREG_SRL, 16'h0000);
    take(4'h5, SRC_VEC[0]);
    wr({1'b0, REG_FLAG}, 16'h0004);
    wr(HREG_CMD, 16'h0001);
    take(4'h5, SRC_VEC[2]);
    wr(HREG_CMD, 16'h0001);
    take(4'h5, SRC_VEC[2]);
    wr({1'b0, REG_FLAG}, 16'h0000);
    wr(HREG_CMD, 16'h0001);
    wr(HREG_IRQ_CLR, 16'h0003);
    // Timed disable holds level six but not level seven
    wr({1'b0, REG_PRIO0}, 16'h7006);
    wr(HREG_CMD, 16'h0002);
    pulse(10'h001, 8'h00);
    repeat (8) @(posedge clock);
    rd(HREG_IRQ_STAT, 16'h0000);
    pulse(10'h004, 8'h00);
    take(4'h7, SRC_VEC[2]);
    wr({1'b0, REG_FLAG}, 16'h0001);
    wr(HREG_CMD, 16'h0001);
    take(4'h6, SRC_VEC[0]);
    // Nesting disabled: level seven waits for the running routine
    wr({1'b0, REG_CTRL}, 16'h8000);
    wr({1'b0, REG_FLAG}, 16'h0000);
    pulse(10'h004, 8'h00);
    repeat (8) @(posedge clock);
    rd(HREG_LAST_VEC, taken_word(4'h6, SRC_VEC[0]));
    wr(HREG_CMD, 16'h0001);
    take(4'h7, SRC_VEC[2]);
    report_and_stop();
  end
endmodule : tb_interrupt_priority_control
